// File: src/drrc_regs.svh
// register offsets, field positions, reset values and interval counts of the refresh block
`ifndef DRRC_REGS_SVH
`define DRRC_REGS_SVH

`define DRRC_RENEW_CONTROL_ADDR 8'h36
`define DRRC_RENEW_ENABLE_BIT 7
`define DRRC_RENEW_WAIT_SELECT_BIT 6
`define DRRC_INTERVAL_SEL_HI_BIT 1
`define DRRC_INTERVAL_SEL_LO_BIT 0
`define DRRC_RENEW_CONTROL_RESET 8'hc3
`define DRRC_RENEW_CONTROL_RESET_VAL 8'hc0
`define DRRC_RENEW_CONTROL_MASK 8'hc3

`define DRRC_INTERVAL_SEL0_STATES 7'h0a
`define DRRC_INTERVAL_SEL1_STATES 7'h14
`define DRRC_INTERVAL_SEL2_STATES 7'h28
`define DRRC_INTERVAL_SEL3_STATES 7'h50

`define DRRC_ROW_RESET 8'h00
`define DRRC_ROW_STEP 8'h01

`endif

// File: src/drrc_pkg.sv
// types shared by the refresh block
package drrc_pkg;

  typedef enum logic [1:0] {
    DRRC_IDLE,
    DRRC_T1,
    DRRC_T2,
    DRRC_TRW
  } drrc_state_t;

  typedef struct packed {
    logic mc_boundary;
    logic bus_released;
    logic sleep_mode;
    logic wait_active;
  } drrc_bus_status_t;

  typedef struct packed {
    logic [7:0] addr_lo;
    logic addr_lo_en;
    logic renew_strobe_n;
    logic cpu_hold;
  } drrc_renew_bus_t;

endpackage

// File: src/drrc_interval_timer.sv
// free running refresh interval timer, one tick per elapsed interval
`timescale 1ns/10ps
`default_nettype none
module drrc_interval_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // interval length in clock states
  input wire logic [6:0] interval_states,
  // one cycle pulse at the end of each interval
  output logic tick
);

  logic [6:0] count;
  logic [6:0] next_count;
  logic last_state;

  assign last_state = (count >= (interval_states - 7'h01));
  assign next_count = last_state ? 7'h00 : (count + 7'h01);

  // restarts at once, never waits for the request to be served
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= 7'h00;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= last_state;
    end
  end

endmodule
`default_nettype wire

// File: src/drrc_row_counter.sv
// refresh row address counter, advanced once per performed refresh cycle
`timescale 1ns/10ps
`default_nettype none
`include "drrc_regs.svh"
module drrc_row_counter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // advance strobe
  input wire logic advance,
  // current row
  output logic [7:0] row
);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      row <= `DRRC_ROW_RESET;
    end else if (advance) begin
      row <= row + `DRRC_ROW_STEP;
    end
  end

endmodule
`default_nettype wire

// File: src/drrc_top.sv
// dynamic RAM refresh controller: control register, request logic and cycle sequencer
//
// What this block does
// - own 8-bit refresh row address and programmable interval, independent of program.
// - pending refresh is inserted at the next machine cycle boundary.
// - during refresh, row address on address bits 7:0 and strobe driven low.
// - external wait input and internal wait states are ignored during refresh.
// - control bit 7 enables refresh insertion; reset sets it to one.
// - control bit 6 selects two or three clock refresh cycle; reset sets one.
// - control bits 1:0 pick 10, 20, 40 or 80 states; reset clears them.
// - no insertion during reset, bus release, sleep or wait states.
// - bus release drops requests but the interval timer keeps running.
// - request during sleep stays pending, inserted after first cycle past sleep.
// - row address advances by one only for each performed refresh cycle.
`timescale 1ns/10ps
`default_nettype none
`include "drrc_regs.svh"
module drrc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // internal i/o register port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // cpu bus sequencer status
  input wire drrc_pkg::drrc_bus_status_t bus_status,
  // wait sources from the pins and the wait generator
  input wire logic ext_wait_n,
  input wire logic int_wait_req,
  output logic cpu_wait_n,
  output logic int_wait_en,
  // refresh bus cycle
  output drrc_pkg::drrc_renew_bus_t renew_bus,
  output logic renew_pending
);

  logic [7:0] dram_renew_control;
  logic renew_enable;
  logic renew_wait_select;
  logic [1:0] interval_sel;
  logic [6:0] interval_states;
  logic timer_tick;
  logic [7:0] row;
  logic row_advance;
  logic reg_sel;
  logic start_cycle;
  logic in_cycle;
  logic cycle_done;
  drrc_pkg::drrc_state_t state;
  drrc_pkg::drrc_state_t next_state;

  // interval field to number of clock states
  function automatic logic [6:0] drrc_interval_decode(input logic [1:0] sel);
    logic [6:0] states;
    states = `DRRC_INTERVAL_SEL0_STATES;
    case (sel)
      2'b00: states = `DRRC_INTERVAL_SEL0_STATES;
      2'b01: states = `DRRC_INTERVAL_SEL1_STATES;
      2'b10: states = `DRRC_INTERVAL_SEL2_STATES;
      2'b11: states = `DRRC_INTERVAL_SEL3_STATES;
      default: states = `DRRC_INTERVAL_SEL0_STATES;
    endcase
    return states;
  endfunction

  // ---------------- control register ----------------

  assign reg_sel = (io_addr == `DRRC_RENEW_CONTROL_ADDR);
  assign io_hit = reg_sel && (io_wr || io_rd);

  // reset leaves enable and wait select set, interval cleared
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dram_renew_control <= `DRRC_RENEW_CONTROL_RESET_VAL;
    end else if (io_wr && reg_sel) begin
      dram_renew_control <= io_wdata & `DRRC_RENEW_CONTROL_MASK;
    end
  end

  assign renew_enable = dram_renew_control[`DRRC_RENEW_ENABLE_BIT];
  assign renew_wait_select = dram_renew_control[`DRRC_RENEW_WAIT_SELECT_BIT];
  assign interval_sel = {dram_renew_control[`DRRC_INTERVAL_SEL_HI_BIT],
                         dram_renew_control[`DRRC_INTERVAL_SEL_LO_BIT]};

  // read data held in a flop; reserved bits and unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= reg_sel ? dram_renew_control : 8'h00;
    end
  end

  // ---------------- interval timer ----------------

  assign interval_states = drrc_interval_decode(interval_sel);

  // keeps counting through bus release, sleep and disabled refresh
  drrc_interval_timer u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .interval_states(interval_states),
    .tick(timer_tick)
  );

  // ---------------- request latch ----------------

  // a new tick wins over the clear from a starting cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      renew_pending <= 1'b0;
    end else if (!renew_enable) begin
      renew_pending <= 1'b0;
    end else if (bus_status.bus_released) begin
      renew_pending <= 1'b0;
    end else if (timer_tick) begin
      renew_pending <= 1'b1;
    end else if (start_cycle) begin
      renew_pending <= 1'b0;
    end
  end

  // held through sleep; inserted at the first boundary once awake
  assign start_cycle = (state == drrc_pkg::DRRC_IDLE) && renew_pending && renew_enable
                       && bus_status.mc_boundary
                       && !bus_status.bus_released && !bus_status.sleep_mode
                       && !bus_status.wait_active;

  // ---------------- refresh cycle sequencer ----------------

  always_comb begin
    next_state = state;
    case (state)
      drrc_pkg::DRRC_IDLE: begin
        if (start_cycle) begin
          next_state = drrc_pkg::DRRC_T1;
        end
      end
      drrc_pkg::DRRC_T1: begin
        next_state = drrc_pkg::DRRC_T2;
      end
      drrc_pkg::DRRC_T2: begin
        next_state = renew_wait_select ? drrc_pkg::DRRC_TRW : drrc_pkg::DRRC_IDLE;
      end
      drrc_pkg::DRRC_TRW: begin
        next_state = drrc_pkg::DRRC_IDLE;
      end
      default: begin
        next_state = drrc_pkg::DRRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= drrc_pkg::DRRC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign in_cycle = (state != drrc_pkg::DRRC_IDLE);
  assign cycle_done = in_cycle && (next_state == drrc_pkg::DRRC_IDLE);

  // ---------------- row address ----------------

  assign row_advance = cycle_done;

  drrc_row_counter u_row (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .advance(row_advance),
    .row(row)
  );

  // ---------------- wait gating ----------------

  // wait sources blocked while a refresh cycle runs
  assign cpu_wait_n = in_cycle ? 1'b1 : ext_wait_n;
  assign int_wait_en = int_wait_req && !in_cycle;

  // ---------------- refresh bus outputs ----------------

  // registered so that address and strobe appear with the first refresh state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      renew_bus.addr_lo <= `DRRC_ROW_RESET;
      renew_bus.addr_lo_en <= 1'b0;
      renew_bus.renew_strobe_n <= 1'b1;
      renew_bus.cpu_hold <= 1'b0;
    end else begin
      renew_bus.addr_lo <= row;
      renew_bus.addr_lo_en <= (next_state != drrc_pkg::DRRC_IDLE);
      renew_bus.renew_strobe_n <= (next_state == drrc_pkg::DRRC_IDLE);
      renew_bus.cpu_hold <= (next_state != drrc_pkg::DRRC_IDLE);
    end
  end

endmodule
`default_nettype wire

// File: bench/drrc_assertions.sv
// port checker for the refresh block
`timescale 1ns/10ps
`default_nettype none
module drrc_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  // bus side
  input wire drrc_pkg::drrc_bus_status_t bus_status,
  input wire logic cpu_wait_n,
  input wire logic int_wait_en,
  input wire drrc_pkg::drrc_renew_bus_t renew_bus,
  input wire logic renew_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic s_n = renew_bus.renew_strobe_n;
  sequence s_on;
    $fell(s_n);
  endsequence
  property p_bus;
    !s_n |-> renew_bus.addr_lo_en && renew_bus.cpu_hold
      && ($fell(s_n) || $stable(renew_bus.addr_lo));
  endproperty
  a_bus: assert property (p_bus) else $error("strobe without address");
  property p_wt;
    !s_n |-> cpu_wait_n && !int_wait_en;
  endproperty
  a_wt: assert property (p_wt) else $error("wait seen in refresh");
  property p_len;
    s_on |-> ##1 !s_n ##[1:2] s_n;
  endproperty
  a_len: assert property (p_len) else $error("bad refresh length");
  property p_row;
    $rose(s_n) |=> renew_bus.addr_lo == $past(renew_bus.addr_lo) + 8'h01;
  endproperty
  a_row: assert property (p_row) else $error("row not stepped");
  property p_go;
    s_on |-> $past(bus_status.mc_boundary && !bus_status.bus_released
      && !bus_status.sleep_mode && !bus_status.wait_active && renew_pending);
  endproperty
  a_go: assert property (p_go) else $error("bad refresh start");
  property p_rel;
    bus_status.bus_released |=> !renew_pending;
  endproperty
  a_rel: assert property (p_rel) else $error("request kept on release");
  property p_slp;
    renew_pending && bus_status.sleep_mode && !bus_status.bus_released |=> renew_pending;
  endproperty
  a_slp: assert property (p_slp) else $error("request lost in sleep");
  property p_unm;
    io_rd && io_addr != 8'h36 |=> io_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// File: bench/drrc_cpu_model.sv
// cpu bus sequencer model giving machine cycle ends
`timescale 1ns/10ps
`default_nettype none
module drrc_cpu_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bench controls: slow cycles, released/sleep/wait
  input wire logic slow,
  input wire logic [2:0] ctl,
  // refresh hold
  input wire logic cpu_hold,
  // status
  output drrc_pkg::drrc_bus_status_t bus_status
);
  logic [1:0] ph;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
    end
  end
  // no cycle ends while held
  assign bus_status = {!cpu_hold && (!slow || ph == 2'h3), ctl};
endmodule
`default_nettype wire

// File: bench/dram_refresh_control_test.sv
// testbench of the refresh block
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_control_test;
  logic clk_sys, rst_b, io_wr, io_rd, io_hit, cpu_wait_n, int_wait_en, pend, slow, sp;
  logic [7:0] io_addr, io_wdata, io_rdata, row, nlow, len;
  logic [2:0] ctl;
  drrc_pkg::drrc_bus_status_t st;
  drrc_pkg::drrc_renew_bus_t rb;
  int errors, check_count, cyc, nref, tf, tp, n;
  drrc_cpu_model u_cpu (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .ctl(ctl),
    .cpu_hold(rb.cpu_hold), .bus_status(st));
  drrc_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .bus_status(st), .ext_wait_n(1'b0), .int_wait_req(1'b1), .cpu_wait_n(cpu_wait_n),
    .int_wait_en(int_wait_en), .renew_bus(rb), .renew_pending(pend));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys) io_addr = a;
    io_rd = 1;
    #2 chk("hit", io_hit, 8'(a == 8'h36));
    @(negedge clk_sys) io_rd = 0;
    chk("rdata", io_rdata, e);
  endtask
  // wait states hold off refresh before and during the write
  task automatic qwr(input logic [7:0] d);
    ctl = 3'b001;
    repeat (4) @(negedge clk_sys);
    io_addr = 8'h36;
    io_wdata = d;
    io_wr = 1;
    @(negedge clk_sys) io_wr = 0;
    len = d[6] ? 8'h03 : 8'h02;
    ctl = 3'b000;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      errors++;
      finish_test();
    end
  end
  always @(negedge clk_sys) begin
    if (!rb.renew_strobe_n) begin
      if (sp) begin
        nref++;
        tp = tf;
        tf = cyc;
        chk("row", rb.addr_lo, row);
      end
      chk("waits", {cpu_wait_n, int_wait_en}, 8'h02);
      nlow++;
    end else if (!sp) begin
      chk("length", nlow, len);
      nlow = 0;
      row++;
    end
    if (rb.renew_strobe_n) chk("fwd", {cpu_wait_n, int_wait_en}, 8'h01);
    sp = rb.renew_strobe_n;
  end
  initial begin
    {io_wr, io_rd, slow, rst_b, ctl, io_addr, io_wdata, row, nlow, cyc, nref} = '0;
    {sp, len, tf} = {1'b1, 8'h03, 32'h0};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1;
    rd(8'h36, 8'hc0);
    rd(8'h37, 8'h00);
    repeat (60) @(negedge clk_sys);
    chk("spacing", 8'(tf - tp), 8'd10);
    for (int i = 0; i < 4; i++) begin
      qwr(8'h80 | 8'(i));
      repeat (300) @(negedge clk_sys);
      chk("spacing", 8'(tf - tp), 8'd10 << i);
    end
    qwr(8'hff);
    rd(8'h36, 8'hc3);
    slow = 1;
    repeat (200) @(negedge clk_sys);
    qwr(8'h00);
    n = nref;
    repeat (200) @(negedge clk_sys);
    chk("count", 8'(nref - n), 8'h00);
    qwr(8'h80);
    @(negedge clk_sys) slow = 0;
    for (int i = 0; i < 3; i++) begin
      ctl = i[0] ? 3'b100 : (i[1] ? 3'b010 : 3'b001);
      n = nref;
      repeat (60) @(negedge clk_sys);
      chk("count", 8'(nref - n), 8'h00);
    end
    chk("pending", pend, 8'h01);
    ctl = 3'b000;
    repeat (3) @(negedge clk_sys);
    chk("count", 8'(nref - n), 8'h01);
    finish_test();
  end
endmodule
bind drrc_top drrc_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .io_addr(io_addr),
  .io_rd(io_rd), .io_rdata(io_rdata), .bus_status(bus_status), .cpu_wait_n(cpu_wait_n),
  .int_wait_en(int_wait_en), .renew_bus(renew_bus), .renew_pending(renew_pending));
`default_nettype wire
